// [design/fidsr_sync.sv]
// Purpose: Two-stage synchroniser for pins from outside the core clock.
// Assumes: Each bit is an independent level; no bus coherence.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps

module fidsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // ========================================================================
  // Two flops, reset to a constant
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// [design/fidsr_top.sv]
// Purpose: Command logic for identity, signature, maker/device pair and status reads.
// Assumes: Serial clock and select are slow enough to be oversampled by mclk_i.
// Notes:   Program/erase/status-write engines live elsewhere and report busy.
`timescale 1ns/1ps

module fidsr_top import fidsr_pkg::*; #(
  parameter int WAKE_CYC = WAKE_CYCLES,
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Value arbitrary
  parameter logic [7:0] TYPE_CODE = 8'h3c,  // Value arbitrary
  parameter logic [7:0] DEVICE_CODE = 8'h17  // Value arbitrary
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] sio_i,
  input wire logic hw_reset_n_i,
  input wire logic four_line_command_mode_i,
  input wire logic busy_flag_i,
  input wire logic write_latch_flag_i,
  input wire logic [5:0] status_upper_i,
  input wire logic deep_sleep_req_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o,
  output logic deep_sleep_o,
  output logic standby_o
);

  localparam int WCW = $clog2(WAKE_CYC + 1);

  // ========================================================================
  // Pin synchronisers
  logic sclk_s;
  logic cs_n_s;
  logic hw_reset_n_s;
  logic [3:0] sio_s;

  fidsr_sync #(
    .WIDTH(7),
    .RESET_VAL(7'h30)  // Idle levels: select and reset pin high, so no false edge after reset
  ) u_sync (
    .clk_i(mclk_i),
    .resetn_i(resetn_i),
    .d_i({sclk_i, cs_n_i, hw_reset_n_i, sio_i}),
    .q_o({sclk_s, cs_n_s, hw_reset_n_s, sio_s})
  );

  // ========================================================================
  // State
  fidsr_state_e state_q;
  fidsr_out_e kind_q;
  logic sclk_p_q;
  logic cs_p_q;
  logic quad_q;
  logic deep_q;
  logic wake_arm_q;
  logic pair_dev_q;  // Pair order; each 16-bit unit is rebuilt from it on reload
  logic [7:0] sh_q;
  logic [4:0] cnt_q;
  logic [23:0] dat_q;
  logic [WCW-1:0] wake_q;
  logic [3:0] sio_q;
  logic [3:0] oe_q;
  logic standby_q;

  // ========================================================================
  // Edge detection on the synchronised pins
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  assign sclk_rise = sclk_s & ~sclk_p_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_p_q & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_p_q;
  assign cs_fall = ~cs_n_s & cs_p_q;

  // ========================================================================
  // Input shifting: one line ignores the upper lines, four lines take a nibble
  logic [4:0] step;
  logic [7:0] sh_in;
  logic [4:0] cnt_in;
  logic cmd_done;
  logic addr_done;
  assign step = quad_q ? STEP_QUAD : STEP_SINGLE;
  assign sh_in = quad_q ? {sh_q[3:0], sio_s} : {sh_q[6:0], sio_s[0]};
  assign cnt_in = cnt_q + step;
  assign cmd_done = sclk_rise && (state_q == ST_CMD) && (cnt_in == CMD_BITS);
  assign addr_done = sclk_rise && (state_q == ST_ADDR) && (cnt_in == PAIR_ADDR_BITS);

  // ========================================================================
  // Command decode; deep sleep admits only the signature/wake code
  logic is_jedec;
  logic is_sig;
  logic is_pair;
  logic is_quad_id;
  logic is_stat;
  logic take_sig;
  assign is_jedec = (sh_in == CMD_READ_JEDEC_IDENTITY) && !quad_q && !busy_flag_i && !deep_q;
  assign take_sig = (sh_in == CMD_READ_LEGACY_SIGNATURE) && !busy_flag_i;
  assign is_sig = take_sig;
  assign is_pair = (sh_in == CMD_READ_MAKER_DEVICE_PAIR) && !quad_q && !busy_flag_i && !deep_q;
  assign is_quad_id = (sh_in == CMD_QUAD_IDENTITY_READ) && quad_q && !busy_flag_i && !deep_q;
  assign is_stat = (sh_in == CMD_READ_STATUS_BYTE) && !deep_q;

  // ========================================================================
  // Output unit: each kind reloads its word when the previous one is spent
  logic [7:0] stat_byte;
  logic [23:0] ld_word;
  logic [4:0] ld_len;
  logic [23:0] src;
  logic [4:0] rem_base;
  assign stat_byte = {status_upper_i, write_latch_flag_i, busy_flag_i};
  assign ld_word = (kind_q == OUT_IDENT) ? {MAKER_CODE, TYPE_CODE, DEVICE_CODE} :
                   (kind_q == OUT_SIG) ? {DEVICE_CODE, 16'h0000} :
                   (kind_q == OUT_PAIR && pair_dev_q) ? {DEVICE_CODE, MAKER_CODE, 8'h00} :
                   (kind_q == OUT_PAIR) ? {MAKER_CODE, DEVICE_CODE, 8'h00} :
                   {stat_byte, 16'h0000};
  assign ld_len = (kind_q == OUT_IDENT) ? LEN_IDENTITY : (kind_q == OUT_PAIR) ? LEN_PAIR : LEN_BYTE;
  assign src = (cnt_q == 5'h00) ? ld_word : dat_q;
  assign rem_base = (cnt_q == 5'h00) ? ld_len : cnt_q;

  // Next bits on the pins and the shifted remainder
  logic [3:0] drv_bits;
  logic [23:0] dat_shift;
  assign drv_bits = quad_q ? src[23:20] : {2'b00, src[23], 1'b0};
  assign dat_shift = quad_q ? {src[19:0], 4'h0} : {src[22:0], 1'b0};

  // ========================================================================
  // Sampled history of clock and select
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      cs_p_q <= cs_n_s;
    end
  end

  // ========================================================================
  // Command sequencer
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      kind_q <= OUT_STAT;
      quad_q <= 1'b0;
      deep_q <= 1'b0;
      wake_arm_q <= 1'b0;
      pair_dev_q <= 1'b0;
      sh_q <= 8'h00;
      cnt_q <= 5'h00;
      dat_q <= 24'h000000;
      wake_q <= '0;
    end else if (!hw_reset_n_s) begin
      state_q <= ST_IDLE;  // Pin reset aborts any transaction
      deep_q <= 1'b0;
      wake_arm_q <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (deep_sleep_req_i && !busy_flag_i) begin
            deep_q <= 1'b1;
          end
          if (cs_fall) begin
            state_q <= ST_CMD;
            quad_q <= four_line_command_mode_i;  // Mode frozen for the frame
            cnt_q <= 5'h00;
            wake_arm_q <= 1'b0;
          end
        end
        ST_CMD: begin
          if (cs_rise) begin
            state_q <= ST_IDLE;
          end else if (sclk_rise) begin
            sh_q <= sh_in;
            cnt_q <= cmd_done ? 5'h00 : cnt_in;
            if (cmd_done) begin
              // Decode on the last command edge; output begins on the next fall, or after the address phase for the pair read
              if (is_jedec || is_quad_id) begin
                state_q <= ST_OUT;
                kind_q <= OUT_IDENT;
              end else if (is_sig) begin
                state_q <= ST_OUT;
                kind_q <= OUT_SIG;
                wake_arm_q <= 1'b1;
              end else if (is_pair) begin
                state_q <= ST_ADDR;
                kind_q <= OUT_PAIR;
              end else if (is_stat) begin
                state_q <= ST_OUT;
                kind_q <= OUT_STAT;
              end else begin
                state_q <= ST_SKIP;  // Refused code: busy engine is untouched
              end
            end
          end
        end
        ST_ADDR: begin
          if (cs_rise) begin
            state_q <= ST_IDLE;
          end else if (sclk_rise) begin
            sh_q <= sh_in;
            cnt_q <= addr_done ? 5'h00 : cnt_in;
            if (addr_done) begin
              state_q <= ST_OUT;
              pair_dev_q <= sh_in[0];  // Address bit 0 set gives device code first
            end
          end
        end
        ST_OUT: begin
          if (cs_rise) begin
            state_q <= (wake_arm_q && deep_q) ? ST_WAKE : ST_IDLE;
            wake_q <= WCW'(WAKE_CYC);
            cnt_q <= 5'h00;
          end else if (sclk_fall) begin
            dat_q <= dat_shift;
            cnt_q <= rem_base - step;
          end
        end
        ST_SKIP: begin
          if (cs_rise) begin
            state_q <= (wake_arm_q && deep_q) ? ST_WAKE : ST_IDLE;
          end
        end
        ST_WAKE: begin
          // Select falls are ignored here; the host waits out the delay
          if (wake_q <= WCW'(1)) begin
            state_q <= ST_IDLE;
            deep_q <= 1'b0;
          end else begin
            wake_q <= wake_q - WCW'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Pin drivers, changed only on serial falling edges, deselect or the reset pin going low
  logic out_act;
  assign out_act = (state_q == ST_OUT) && hw_reset_n_s;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sio_q <= 4'h0;
      oe_q <= OE_NONE;
    end else if (!out_act || cs_rise) begin
      sio_q <= 4'h0;
      oe_q <= OE_NONE;  // Release lines as soon as select rises
    end else if (sclk_fall) begin
      sio_q <= drv_bits;
      oe_q <= quad_q ? OE_QUAD : OE_SINGLE;
    end
  end

  // ========================================================================
  // Power state flags
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= (state_q == ST_IDLE) && !deep_q;
    end
  end

  assign sio_o = sio_q;
  assign sio_oe_o = oe_q;
  assign deep_sleep_o = deep_q;
  assign standby_o = standby_q;

endmodule

// [include/fidsr_pkg.sv]
// Purpose: Shared constants for the identity and status readout command logic.
// Assumes: Core clock of 250 MHz; serial pins sampled, not used as clocks.
// Notes:   Identity values live as top-level parameters, not here.

// ==========================================================================
// Package
package fidsr_pkg;

  // ========================================================================
  // Timing
  localparam int MCLK_PERIOD_NS = 4;
  localparam int WAKE_DELAY_NS = 30000;  // Settling time out of deep sleep
  // Round up: the device must never report standby early
  localparam int WAKE_CYCLES = (WAKE_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // ========================================================================
  // Command codes
  localparam logic [7:0] CMD_READ_JEDEC_IDENTITY = 8'h9f;
  localparam logic [7:0] CMD_READ_LEGACY_SIGNATURE = 8'hab;  // Also the wake command
  localparam logic [7:0] CMD_READ_MAKER_DEVICE_PAIR = 8'h90;
  localparam logic [7:0] CMD_QUAD_IDENTITY_READ = 8'haf;
  localparam logic [7:0] CMD_READ_STATUS_BYTE = 8'h05;

  // ========================================================================
  // Phase lengths in bits
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] PAIR_ADDR_BITS = 5'h18;  // Two dummy bytes plus address
  localparam logic [4:0] LEN_IDENTITY = 5'h18;
  localparam logic [4:0] LEN_PAIR = 5'h10;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] STEP_SINGLE = 5'h01;
  localparam logic [4:0] STEP_QUAD = 5'h04;

  // ========================================================================
  // Status byte fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;

  // ========================================================================
  // Pin enables
  localparam logic [3:0] OE_SINGLE = 4'h2;  // Serial output is line 1
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam logic [3:0] OE_NONE = 4'h0;

  // ========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD  = 3'b001,
    ST_ADDR = 3'b010,
    ST_OUT  = 3'b011,
    ST_SKIP = 3'b100,
    ST_WAKE = 3'b101
  } fidsr_state_e;

  typedef enum logic [1:0] {
    OUT_IDENT = 2'b00,
    OUT_SIG   = 2'b01,
    OUT_PAIR  = 2'b10,
    OUT_STAT  = 2'b11
  } fidsr_out_e;

endpackage

// [verif/fidsr_host_model.sv]
// Purpose: Host controller driving select, shift clock and data lines.
// Assumes: Device outputs settle well within half a shift clock.
// Notes:   Shift clock stands low outside frames; 125 ns period.
`timescale 1ns/1ps

module fidsr_host_model (
  input wire logic [3:0] sio_o,
  input wire logic [3:0] sio_oe_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] sio_out_o
);
  localparam realtime HALF = 62.5;

  // ==========
  // Idle lines; data never rests at a stale value
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sio_out_o = 4'h5;
  end

  // One shift clock; bits are set while the clock is low
  task automatic tick(input logic [3:0] v);
    sio_out_o = v;
    #HALF sclk_o = 1'b1;
    #HALF sclk_o = 1'b0;
  endtask

  task automatic sel;
    cs_n_o = 1'b0;
    #HALF;
  endtask

  // Byte MSB first; upper lines toggle in one-line mode as they must be ignored
  task automatic send(input logic [7:0] b, input bit quad);
    if (quad) begin
      tick(b[7:4]);
      tick(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) tick({~sio_out_o[3:1], b[i]});
    end
  endtask

  // Sample at the rising edge, half a clock after the device updated
  task automatic rd(input int n, input bit quad, output logic [47:0] d);
    logic [3:0] line;
    d = '0;
    for (int k = 0; k < n; k++) begin
      sio_out_o = ~sio_out_o;
      #HALF sclk_o = 1'b1;
      // Released lines float to the pull-up, so a silent device reads as ones
      line = (sio_o & sio_oe_o) | ~sio_oe_o;
      d = quad ? {d[43:0], line} : {d[46:0], line[1]};
      #HALF sclk_o = 1'b0;
    end
  endtask

  // Select high, held past the minimum gap between frames
  task automatic desel;
    cs_n_o = 1'b1;
    sio_out_o = ~sio_out_o;
    #40;
  endtask
endmodule

// [verif/fidsr_monitor.sv]
// Purpose: Port-level checks for the identity and status readout block.
// Assumes: Host keeps the command mode pin steady while selected.
// Notes:   Bound to every fidsr_top instance; sees ports only.
`timescale 1ns/1ps

module fidsr_monitor import fidsr_pkg::*; #(
  parameter int WAKE_CYC = WAKE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic hw_reset_n_i,
  input wire logic four_line_command_mode_i,
  input wire logic [3:0] sio_o,
  input wire logic [3:0] sio_oe_o,
  input wire logic deep_sleep_o,
  input wire logic standby_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // ==========
  // Helpers
  // Select-high run length; saturates so a long idle never wraps to zero
  logic [15:0] hi_q;
  // Cycles since the reset pin was last low, so pin wakes are told apart
  logic [3:0] quiet_q;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_q <= '0;
      quiet_q <= '0;
    end else begin
      hi_q <= !cs_n_i ? '0 : ((hi_q == 16'hffff) ? hi_q : hi_q + 16'h1);
      quiet_q <= !hw_reset_n_i ? '0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
    end
  end

  // ==========
  // Assertions
  property p_idle_oe; cs_n_i [*6] |-> sio_oe_o == OE_NONE; endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("Lines driven while deselected");
  property p_quad_oe; sio_oe_o == OE_QUAD |-> four_line_command_mode_i; endproperty
  a_quad_oe: assert property (p_quad_oe) else $error("Four lines driven in one-line mode");
  property p_single_oe; sio_oe_o == OE_SINGLE |-> !four_line_command_mode_i; endproperty
  a_single_oe: assert property (p_single_oe) else $error("One line driven in four-line mode");
  property p_pin_wake; !hw_reset_n_i [*6] |-> !deep_sleep_o && sio_oe_o == OE_NONE; endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("Reset pin did not release sleep");
  property p_wake_delay; $fell(deep_sleep_o) && quiet_q == 4'hf |-> hi_q >= WAKE_CYC; endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("Woke before the wake delay");
  property p_wake_standby; $fell(deep_sleep_o) && quiet_q == 4'hf |-> ##[0:3] standby_o; endproperty
  a_wake_standby: assert property (p_wake_standby) else $error("No standby after wake");
  property p_out_stable; (sclk_i && !cs_n_i) [*6] |-> $stable(sio_o); endproperty
  a_out_stable: assert property (p_out_stable) else $error("Data moved off a falling edge");
  property p_sleep_excl; deep_sleep_o && $past(deep_sleep_o) |-> !standby_o; endproperty
  a_sleep_excl: assert property (p_sleep_excl) else $error("Standby shown in deep sleep");
endmodule

bind fidsr_top fidsr_monitor #(.WAKE_CYC(WAKE_CYC)) u_mon (.mclk_i, .resetn_i, .sclk_i, .cs_n_i,
  .hw_reset_n_i, .four_line_command_mode_i, .sio_o, .sio_oe_o, .deep_sleep_o, .standby_o);

// [verif/tb.sv]
// Purpose: Self-checking bench for the identity and status readout block.
// Assumes: Wake delay shortened to 20 core clocks.
// Notes:   Identity values are arbitrary test values.
`timescale 1ns/1ps
`define CHK(n,e,s) begin cmp_count++; if ((s)!==(e)) begin failures++; $display("[ERR] %s exp %h got %h",n,e,s); end end

module tb;
  import fidsr_pkg::*;
  localparam int WK = 20;
  localparam logic [7:0] MK = 8'h5a;  // Value arbitrary
  localparam logic [7:0] TY = 8'h3c;  // Value arbitrary
  localparam logic [7:0] DV = 8'h17;  // Value arbitrary
  localparam logic [47:0] ID2 = {MK, TY, DV, MK, TY, DV};
  localparam logic [31:0] PR0 = {MK, DV, MK, DV};
  localparam logic [31:0] PR1 = {DV, MK, DV, MK};
  localparam logic [15:0] SIG2 = {DV, DV};
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hw_n = 1'b1;
  logic mode = 1'b0;
  logic busy = 1'b0;
  logic latch = 1'b0;
  logic sleep_req = 1'b0;
  logic [5:0] upper = 6'h00;
  logic [47:0] d;
  int failures = 0;
  int cmp_count = 0;
  wire sclk, cs_n, deep, stby;
  wire [3:0] sio_in, sio_o, sio_oe_o;

  // ==========
  // Clock, design and host
  always #2 mclk_i = ~mclk_i;

  fidsr_top #(.WAKE_CYC(WK), .MAKER_CODE(MK), .TYPE_CODE(TY), .DEVICE_CODE(DV)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .sio_i(sio_in),
    .hw_reset_n_i(hw_n), .four_line_command_mode_i(mode), .busy_flag_i(busy),
    .write_latch_flag_i(latch), .status_upper_i(upper), .deep_sleep_req_i(sleep_req),
    .sio_o(sio_o), .sio_oe_o(sio_oe_o), .deep_sleep_o(deep), .standby_o(stby));

  fidsr_host_model host (.sio_o(sio_o), .sio_oe_o(sio_oe_o), .sclk_o(sclk), .cs_n_o(cs_n), .sio_out_o(sio_in));

  // ==========
  // Helpers
  task automatic frame(input logic [7:0] c, input bit q, input int n);
    host.sel();
    host.send(c, q);
    host.rd(n, q, d);
  endtask

  task automatic go_sleep;
    @(posedge mclk_i) #1 sleep_req = 1'b1;
    @(posedge mclk_i) #1 sleep_req = 1'b0;
    repeat (4) @(posedge mclk_i);
    `CHK("sleep", 2'b10, {deep, stby})
  endtask

  // ==========
  // Scenarios
  task automatic t_ident;
    frame(CMD_READ_JEDEC_IDENTITY, 0, 48);
    `CHK("ident", ID2, d)
    `CHK("ident oe", OE_SINGLE, sio_oe_o)
    host.desel();
    frame(CMD_READ_JEDEC_IDENTITY, 0, 5);
    `CHK("ident cut", {43'h0, MK[7:3]}, d)
    host.desel();
    `CHK("idle", {OE_NONE, 1'b1}, {sio_oe_o, stby})
    $display("t_ident done");
  endtask

  task automatic t_quad;
    @(posedge mclk_i) #1 mode = 1'b1;
    frame(CMD_QUAD_IDENTITY_READ, 1, 12);
    `CHK("quad id", ID2, d)
    `CHK("quad oe", OE_QUAD, sio_oe_o)
    host.desel();
    frame(CMD_READ_LEGACY_SIGNATURE, 1, 4);
    `CHK("quad sig", SIG2, d[15:0])
    host.desel();
    frame(CMD_READ_JEDEC_IDENTITY, 1, 4);
    `CHK("quad refuse", OE_NONE, sio_oe_o)
    `CHK("quad refuse d", 48'hffff, d)
    host.desel();
    @(posedge mclk_i) #1 mode = 1'b0;
    frame(CMD_QUAD_IDENTITY_READ, 0, 4);
    `CHK("single refuse", OE_NONE, sio_oe_o)
    host.desel();
    $display("t_quad done");
  endtask

  // Busy drops mid-frame; the next repeat of the byte must show it
  task automatic t_stat;
    @(posedge mclk_i) #1 busy = 1'b1;
    latch = 1'b1;
    upper = 6'h2a;
    frame(CMD_READ_STATUS_BYTE, 0, 7);
    `CHK("stat busy", 7'h55, d[6:0])
    @(posedge mclk_i) #1 busy = 1'b0;
    host.rd(9, 0, d);
    `CHK("stat live", 8'haa, d[7:0])
    host.desel();
    @(posedge mclk_i) #1 busy = 1'b1;
    frame(CMD_READ_JEDEC_IDENTITY, 0, 8);
    `CHK("busy ident", OE_NONE, sio_oe_o)
    `CHK("busy ident d", 48'hff, d)
    host.desel();
    frame(CMD_READ_LEGACY_SIGNATURE, 0, 8);
    `CHK("busy sig", OE_NONE, sio_oe_o)
    host.desel();
    @(posedge mclk_i) #1 busy = 1'b0;
    $display("t_stat done");
  endtask

  task automatic t_pair;
    for (int a = 0; a < 2; a++) begin
      host.sel();
      host.send(CMD_READ_MAKER_DEVICE_PAIR, 0);
      host.send(8'h00, 0);
      host.send(8'h00, 0);
      host.send(8'(a), 0);
      host.rd(32, 0, d);
      `CHK("pair", (a == 1) ? PR1 : PR0, d[31:0])
      host.desel();
    end
    $display("t_pair done");
  endtask

  task automatic t_sig;
    frame(CMD_READ_LEGACY_SIGNATURE, 0, 16);
    `CHK("sig", SIG2, d[15:0])
    host.desel();
    `CHK("sig standby", 2'b01, {deep, stby})
    $display("t_sig done");
  endtask

  // Wake by command waits out the delay; the reset pin wakes at once
  task automatic t_sleep;
    go_sleep();
    frame(CMD_READ_STATUS_BYTE, 0, 8);
    `CHK("sleep refuse", OE_NONE, sio_oe_o)
    `CHK("sleep refuse d", 48'hff, d)
    host.desel();
    frame(CMD_READ_LEGACY_SIGNATURE, 0, 8);
    `CHK("sleep sig", DV, d[7:0])
    host.desel();
    `CHK("still asleep", 2'b10, {deep, stby})
    #(WK * 4 + 40);
    `CHK("awake", 2'b01, {deep, stby})
    go_sleep();
    @(posedge mclk_i) #1 hw_n = 1'b0;
    repeat (8) @(posedge mclk_i);
    #1 hw_n = 1'b1;
    `CHK("pin wake", 1'b0, deep)
    $display("t_sleep done");
  endtask

  // ==========
  // Verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    t_ident();
    t_quad();
    t_stat();
    t_pair();
    t_sig();
    t_sleep();
    print_verdict();
  end

  // Tests take about 45 us; allow over six times as much before calling a hang
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
endmodule
